// ==== rtl/sfs_pkg.sv ====
// Shared widths, reset values and encodings for the source flow status readout
package sfs_pkg;

   // Channel and status geometry
   localparam int unsigned CHAN_W      = 8;
   localparam int unsigned NUM_CHAN    = 256;
   localparam int unsigned STAT_W      = 2;
   localparam int unsigned BANK_W      = 4;
   localparam int unsigned BANK_CHAN   = 16;
   localparam int unsigned WORD_W      = BANK_CHAN * STAT_W;

   // Calendar buffer geometry
   localparam int unsigned CAL_ADDR_W  = 9;
   localparam int unsigned CAL_DEPTH   = 512;

   // Reset values
   localparam logic [STAT_W-1:0]     STAT_RST = 2'h0;
   localparam logic [CHAN_W-1:0]     CHAN_RST = 8'h00;
   localparam logic [CAL_ADDR_W-1:0] PTR_RST  = 9'h000;
   localparam logic [WORD_W-1:0]     WORD_RST = 32'h0000_0000;

   // Smallest usable calendar length
   localparam logic [CAL_ADDR_W-1:0] CAL_LEN_MIN = 9'h001;

   // Kind of word arriving from the status-path decoder
   typedef enum logic [1:0] {
      SFS_WORD_IDLE,
      SFS_WORD_FRAME,
      SFS_WORD_STATUS,
      SFS_WORD_DIP2
   } sfs_word_kind_t;

   // Status read build variant
   typedef enum logic {
      SFS_ADDRESSABLE,
      SFS_TRANSPARENT
   } sfs_variant_t;

endpackage

// ==== rtl/sfs_status_table.sv ====
`timescale 1ns/1ps
`default_nettype none
// Per-channel status store with a registered sixteen-channel bank read
module sfs_status_table (
   // Clock and reset
   input  wire logic                          i_sys_clk,
   input  wire logic                          i_rst_n,
   // Update port
   input  wire logic                          i_wr_en,
   input  wire logic [sfs_pkg::CHAN_W-1:0]    i_wr_chan,
   input  wire logic [sfs_pkg::STAT_W-1:0]    i_wr_stat,
   // Bank read port
   input  wire logic [sfs_pkg::BANK_W-1:0]    i_bank,
   output logic      [sfs_pkg::WORD_W-1:0]    o_bank_word
);
   import sfs_pkg::*;

   logic [STAT_W-1:0] stat_r [NUM_CHAN];
   logic [WORD_W-1:0] bank_word_nxt;
   logic [WORD_W-1:0] bank_word_r;

   ////////////////////////////////////////////////////////////////////////////
   // Gather the selected bank, lowest channel in the low bit pair
   always_comb begin
      bank_word_nxt = WORD_RST;
      for (int k = 0; k < BANK_CHAN; k++) begin
         bank_word_nxt[k*STAT_W +: STAT_W] = stat_r[{i_bank, k[BANK_W-1:0]}];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status store; an update and a read of the same channel return the old value
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         for (int c = 0; c < NUM_CHAN; c++) begin
            stat_r[c] <= STAT_RST;
         end
      end else if (i_wr_en) begin
         stat_r[i_wr_chan] <= i_wr_stat;
      end
   end

   // Bank word appears one clock after the select
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         bank_word_r <= WORD_RST;
      end else begin
         bank_word_r <= bank_word_nxt;
      end
   end

   assign o_bank_word = bank_word_r;

endmodule
`default_nettype wire

// ==== rtl/sfs_readout.sv ====
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - In the addressable build every status read signal runs on the status read clock.
// - In the transparent build there is no separate status clock and all outputs run on the status path clock.
// - The addressable build drives a 32-bit word each cycle holding sixteen consecutive channels.
// - The transparent build shows a two-bit output holding the last status received.
// - The bank chosen by the four-bit select appears on the status word on the next clock.
// - Select value n chooses channels 16n+15 down to 16n.
// - The bank select plays no part in the transparent build.
// - An eight-bit channel number names the channel updated in the current cycle.
// - The channel-valid flag is high only while the channel number is meaningful.
// - The channel-valid flag is low while framing or DIP-2 words are processed.
// - The channel-valid flag rises only at the start of a new calendar pass.
// - Channels are updated in the order held in the calendar buffer, read by address.
module sfs_readout #(
   parameter sfs_pkg::sfs_variant_t VARIANT = sfs_pkg::SFS_ADDRESSABLE
) (
   // Clock and reset: status path clock, also the status read clock
   input  wire logic                             i_sys_clk,
   input  wire logic                             i_rst_n,
   // Received status stream from the status-path decoder
   input  wire sfs_pkg::sfs_word_kind_t          i_rx_kind,
   input  wire logic [sfs_pkg::STAT_W-1:0]       i_rx_stat,
   // Calendar programming and length
   input  wire logic                             i_cal_wr_en,
   input  wire logic [sfs_pkg::CAL_ADDR_W-1:0]   i_cal_wr_addr,
   input  wire logic [sfs_pkg::CHAN_W-1:0]       i_calendar_entry_write_data,
   input  wire logic [sfs_pkg::CAL_ADDR_W-1:0]   i_cal_len,
   // Addressable status read
   input  wire logic [sfs_pkg::BANK_W-1:0]       i_status_bank_select,
   output logic      [sfs_pkg::WORD_W-1:0]       o_channel_status_out,
   // Transparent status read
   output logic      [sfs_pkg::STAT_W-1:0]       o_channel_status_last,
   output logic      [sfs_pkg::CHAN_W-1:0]       o_updated_channel_number,
   output logic                                  o_updated_channel_valid
);
   import sfs_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Last calendar slot; a zero length is treated as one slot
   function automatic logic [CAL_ADDR_W-1:0] cal_last(input logic [CAL_ADDR_W-1:0] len);
      logic [CAL_ADDR_W-1:0] eff;
      eff = (len < CAL_LEN_MIN) ? CAL_LEN_MIN : len;
      return eff - CAL_LEN_MIN;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic [CHAN_W-1:0]     cal_r [CAL_DEPTH];
   logic [CAL_ADDR_W-1:0] cal_ptr_r;
   logic [CAL_ADDR_W-1:0] cal_ptr_nxt;
   logic [CHAN_W-1:0]     chan_r;
   logic [CHAN_W-1:0]     chan_nxt;
   logic                  valid_r;
   logic                  valid_nxt;
   logic [STAT_W-1:0]     last_stat_r;
   logic [STAT_W-1:0]     last_stat_nxt;

   wire                   is_frame;
   wire                   is_dip;
   wire                   is_stat;
   wire                   pass_start;
   wire                   pass_end;
   wire [CHAN_W-1:0]      slot_chan;
   wire [BANK_W-1:0]      bank_sel;

   ////////////////////////////////////////////////////////////////////////////
   // Word decode

   // Kind of the arriving word
   assign is_frame   = (i_rx_kind == SFS_WORD_FRAME);
   assign is_dip     = (i_rx_kind == SFS_WORD_DIP2);
   assign is_stat    = (i_rx_kind == SFS_WORD_STATUS);

   // Calendar slot that the arriving status belongs to
   assign slot_chan  = cal_r[cal_ptr_r];
   assign pass_start = is_stat && (cal_ptr_r == PTR_RST);
   assign pass_end   = (cal_ptr_r == cal_last(i_cal_len));

   // Transparent build ignores the select so the table port sees a constant
   assign bank_sel   = (VARIANT == SFS_TRANSPARENT) ? '0 : i_status_bank_select;

   ////////////////////////////////////////////////////////////////////////////
   // Calendar buffer, written by the user at any address in any order

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         for (int a = 0; a < CAL_DEPTH; a++) begin
            cal_r[a] <= CHAN_RST;
         end
      end else if (i_cal_wr_en) begin
         cal_r[i_cal_wr_addr] <= i_calendar_entry_write_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Calendar walk

   // Framing realigns the walk; each status word advances it and wraps at the end
   always_comb begin
      cal_ptr_nxt = cal_ptr_r;
      if (is_frame) begin
         cal_ptr_nxt = PTR_RST;
      end else if (is_stat) begin
         cal_ptr_nxt = pass_end ? PTR_RST : cal_ptr_r + CAL_LEN_MIN;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         cal_ptr_r <= PTR_RST;
      end else begin
         cal_ptr_r <= cal_ptr_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Channel number, valid flag and last status

   // Valid is only raised by the first slot, so idle gaps inside a pass
   // keep it high instead of creating a false pass-start edge
   always_comb begin
      chan_nxt      = chan_r;
      valid_nxt     = valid_r;
      last_stat_nxt = last_stat_r;
      if (is_frame || is_dip) begin
         valid_nxt = 1'b0;
      end else if (is_stat) begin
         chan_nxt      = slot_chan;
         last_stat_nxt = i_rx_stat;
         if (pass_start) begin
            valid_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         chan_r      <= CHAN_RST;
         valid_r     <= 1'b0;
         last_stat_r <= STAT_RST;
      end else begin
         chan_r      <= chan_nxt;
         valid_r     <= valid_nxt;
         last_stat_r <= last_stat_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status table and bank read

   // Every status word is written, including those that arrive while valid is low
   sfs_status_table u_table (
      .i_sys_clk   (i_sys_clk),
      .i_rst_n     (i_rst_n),
      .i_wr_en     (is_stat),
      .i_wr_chan   (slot_chan),
      .i_wr_stat   (i_rx_stat),
      .i_bank      (bank_sel),
      .o_bank_word (o_channel_status_out)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all on the one status path clock

   assign o_channel_status_last    = last_stat_r;
   assign o_updated_channel_number = chan_r;
   assign o_updated_channel_valid  = valid_r;

endmodule
`default_nettype wire

// ==== sim/sfs_readout_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module sfs_readout_assertions (
   // Clock, reset and stream
   input wire logic                       i_sys_clk,
   input wire logic                       i_rst_n,
   input wire sfs_pkg::sfs_word_kind_t    i_rx_kind,
   input wire logic [sfs_pkg::STAT_W-1:0] i_rx_stat,
   input wire logic [sfs_pkg::BANK_W-1:0] i_status_bank_select,
   // Outputs watched
   input wire logic [sfs_pkg::WORD_W-1:0] o_channel_status_out,
   input wire logic [sfs_pkg::STAT_W-1:0] o_channel_status_last,
   input wire logic [sfs_pkg::CHAN_W-1:0] o_updated_channel_number,
   input wire logic                       o_updated_channel_valid
);
   import sfs_pkg::*;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   ////////////////////////////////////////////////////////////////
   // Framing word then slot zero opens a calendar pass
   sequence s_new_pass;
      i_rx_kind == SFS_WORD_FRAME ##1 i_rx_kind == SFS_WORD_STATUS;
   endsequence
   property p_pass_start; s_new_pass |=> o_updated_channel_valid; endproperty
   a_pass_start: assert property (p_pass_start) else $error("no valid at pass start");
   property p_rise; $rose(o_updated_channel_valid) |-> $past(i_rx_kind) == SFS_WORD_STATUS; endproperty
   a_rise: assert property (p_rise) else $error("valid rose without status word");
   property p_frame_drop; i_rx_kind == SFS_WORD_FRAME |=> !o_updated_channel_valid; endproperty
   a_frame_drop: assert property (p_frame_drop) else $error("valid high after framing");
   property p_dip_drop; i_rx_kind == SFS_WORD_DIP2 |=> !o_updated_channel_valid; endproperty
   a_dip_drop: assert property (p_dip_drop) else $error("valid high after parity word");
   property p_last; i_rx_kind == SFS_WORD_STATUS |=> o_channel_status_last == $past(i_rx_stat); endproperty
   a_last: assert property (p_last) else $error("last status wrong");
   // Number and last status only move on a status word
   property p_num_hold;
      i_rx_kind != SFS_WORD_STATUS |=> $stable(o_updated_channel_number) && $stable(o_channel_status_last);
   endproperty
   a_num_hold: assert property (p_num_hold) else $error("number moved without status");
   property p_valid_idle; i_rx_kind == SFS_WORD_IDLE |=> $stable(o_updated_channel_valid); endproperty
   a_valid_idle: assert property (p_valid_idle) else $error("valid moved on idle");
   // Word only changes one cycle after a select change or a table write
   property p_bank_stable;
      $stable(i_status_bank_select) && $past(i_rx_kind) != SFS_WORD_STATUS |=> $stable(o_channel_status_out);
   endproperty
   a_bank_stable: assert property (p_bank_stable) else $error("bank word moved");
endmodule
bind sfs_readout sfs_readout_assertions i_chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
   .i_rx_kind(i_rx_kind), .i_rx_stat(i_rx_stat), .i_status_bank_select(i_status_bank_select),
   .o_channel_status_out(o_channel_status_out), .o_channel_status_last(o_channel_status_last),
   .o_updated_channel_number(o_updated_channel_number), .o_updated_channel_valid(o_updated_channel_valid));
`default_nettype wire

// ==== sim/sfs_user_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// User logic reading banks on the status read clock
module sfs_user_model (
   input  wire logic                       i_sys_clk,
   input  wire logic [sfs_pkg::BANK_W-1:0] i_bank_req,
   output var  logic [sfs_pkg::BANK_W-1:0] o_status_bank_select
);
   // Select moves just after the edge, never on it
   initial o_status_bank_select = 4'h0;
   always @(posedge i_sys_clk) o_status_bank_select <= #1 i_bank_req;
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import sfs_pkg::*;
   logic i_sys_clk, i_rst_n, cal_en, vld;
   sfs_word_kind_t kind;
   logic [1:0] stat, last;
   logic [8:0] cal_addr, cal_len;
   logic [7:0] cal_data, num;
   logic [3:0] req, sel;
   logic [31:0] word;
   int err_count, checks;
   // Slots span bank 0, bank 1 and both ends of bank 15
   logic [7:0] cal [4] = '{8'h05, 8'h14, 8'hFF, 8'hF0};
   logic [1:0] st [4] = '{2'h1, 2'h2, 2'h3, 2'h2};
   sfs_readout i_sfs_readout (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_rx_kind(kind), .i_rx_stat(stat),
      .i_cal_wr_en(cal_en), .i_cal_wr_addr(cal_addr), .i_calendar_entry_write_data(cal_data),
      .i_cal_len(cal_len), .i_status_bank_select(sel), .o_channel_status_out(word),
      .o_channel_status_last(last), .o_updated_channel_number(num), .o_updated_channel_valid(vld));
   sfs_user_model i_sfs_user_model (.i_sys_clk(i_sys_clk), .i_bank_req(req), .o_status_bank_select(sel));
   ////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // One stream word, then settle past the edge that takes it
   task automatic step(input sfs_word_kind_t k, input logic [1:0] s);
      kind = k;
      stat = s;
      @(posedge i_sys_clk);
      #1;
   endtask
   task automatic t_program;
      for (int k = 0; k < 4; k++) begin
         cal_en = 1'b1;
         cal_addr = 9'(k);
         cal_data = cal[k];
         @(posedge i_sys_clk);
         #1;
      end
      cal_en = 1'b0;
   endtask
   // Full pass with an idle gap after slot one
   task automatic t_pass(input logic [1:0] x);
      step(SFS_WORD_FRAME, 2'h0);
      check(vld, 1'b0);
      for (int k = 0; k < 4; k++) begin
         step(SFS_WORD_STATUS, st[k] ^ x);
         check(num, cal[k]);
         check(last, st[k] ^ x);
         check(vld, 1'b1);
         if (k == 1) begin
            step(SFS_WORD_IDLE, 2'h0);
            check({vld, num}, {1'b1, cal[1]});
         end
      end
      step(SFS_WORD_DIP2, 2'h0);
      check({vld, num}, {1'b0, cal[3]});
      step(SFS_WORD_IDLE, 2'h0);
   endtask
   // Expected bank word built from the slots written in the pass
   function automatic logic [31:0] exp_word(input logic [3:0] b, input logic [1:0] x);
      exp_word = 32'h0000_0000;
      for (int k = 0; k < 4; k++)
         if (cal[k][7:4] == b) exp_word[2*cal[k][3:0] +: 2] = st[k] ^ x;
   endfunction
   task automatic t_banks(input logic [1:0] x);
      logic [3:0] bl [4] = '{4'h0, 4'h1, 4'h7, 4'hF};
      for (int i = 0; i < 4; i++) begin
         req = bl[i];
         repeat (2) @(posedge i_sys_clk);
         #1;
         check(word, exp_word(bl[i], x));
      end
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      i_sys_clk = 1'b0;
      forever #25 i_sys_clk = ~i_sys_clk;
   end
   // Hang guard
   initial begin
      repeat (5000) @(posedge i_sys_clk);
      err_count++;
      stop_test();
   end
   initial begin
      {i_rst_n, cal_en, stat, req} = '0;
      kind = SFS_WORD_IDLE;
      {cal_addr, cal_data} = '0;
      cal_len = 9'h004;
      repeat (6) @(posedge i_sys_clk);
      #1 i_rst_n = 1'b1;
      @(posedge i_sys_clk);
      #1;
      check(word, 32'h0000_0000);
      check({23'h000000, vld, num}, 32'h0000_0000);
      t_program();
      t_pass(2'h0);
      t_banks(2'h0);
      t_pass(2'h3);
      t_banks(2'h3);
      stop_test();
   end
endmodule
`default_nettype wire
